// [rtl/rx_afc_timeout_mode_control.sv]
// Receiver control: frequency correction, temperature trigger, receive
// timeouts, mode decode and wake-up sequencer.
// Assumes controller bits arrive as synchronous levels and pulses.
`timescale 1ns/1ps
`default_nettype none
module rx_afc_timeout_mode_control (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  mode_field,
  input  wire logic        listen_enable,
  input  wire logic        sequencer_disable,
  input  wire logic [7:0]  bit_divide,
  input  wire logic        auto_correction_enable,
  input  wire logic        auto_clear_enable,
  input  wire logic        correction_start_write,
  input  wire logic        low_index_correction_enable,
  input  wire logic [7:0]  low_index_offset,
  input  wire logic [15:0] freq_error_measured,
  input  wire logic        pll_in_range,
  input  wire logic        temp_start_write,
  input  wire logic [7:0]  temp_sensor_raw,
  input  wire logic        rssi_threshold_flag,
  input  wire logic [7:0]  rx_start_timeout,
  input  wire logic [7:0]  rssi_timeout,
  input  wire logic [23:0] carrier_frequency_init,
  input  wire logic        carrier_frequency_load,
  output logic [23:0]      carrier_frequency,
  output logic [15:0]      freq_correction_value,
  output logic [15:0]      freq_error_value,
  output logic             correction_start,
  output logic             correction_bw_select,
  output logic             temp_running,
  output logic [7:0]       temp_value,
  output logic             timeout_irq,
  output logic [4:0]       active_state,
  output logic             osc_enable,
  output logic             synth_enable,
  output logic             receiver_enable,
  output logic             pll_lock
);
  logic              bit_tick;
  logic              rx_timer_exp;
  logic              rssi_timer_exp;
  rx_ctrl_pkg::op_state_t state;
  rx_ctrl_pkg::op_state_t next_state;
  rx_ctrl_pkg::op_state_t target;
  logic [4:0]        osc_count;
  logic [4:0]        next_osc_count;
  logic              rx_entry;
  logic              rssi_prev;
  logic              rssi_rise;
  logic              afc_busy;
  logic              next_afc_busy;
  logic [2:0]        afc_bits;
  logic [2:0]        next_afc_bits;
  logic [23:0]       next_carrier;
  logic [15:0]       next_corr;
  logic [15:0]       next_fei;
  logic              next_cstart;
  logic [15:0]       offset_steps;
  logic [23:0]       correction_amount;
  logic              temp_busy;
  logic              next_temp_busy;
  logic [11:0]       temp_count;
  logic [11:0]       next_temp_count;
  logic [7:0]        next_temp_value;
  logic              next_timeout;
  logic              next_lock;

  // Mode field to target state
  function automatic rx_ctrl_pkg::op_state_t decode_mode(input logic listen,
                                                         input logic [2:0] m);
    rx_ctrl_pkg::op_state_t r;
    r = rx_ctrl_pkg::ST_SLEEP;
    if (listen) begin
      r = rx_ctrl_pkg::ST_LISTEN;
    end else begin
      case (m)
        rx_ctrl_pkg::MODE_STANDBY: r = rx_ctrl_pkg::ST_STANDBY;
        rx_ctrl_pkg::MODE_SYNTH:   r = rx_ctrl_pkg::ST_SYNTH;
        rx_ctrl_pkg::MODE_RECEIVE: r = rx_ctrl_pkg::ST_RECEIVE;
        default:                   r = rx_ctrl_pkg::ST_SLEEP;
      endcase
    end
    return r;
  endfunction : decode_mode

  bit_rate_divider u_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .divide   (bit_divide),
    .bit_tick (bit_tick)
  );

  assign target    = decode_mode(listen_enable, mode_field);
  assign rx_entry  = (next_state == rx_ctrl_pkg::ST_RECEIVE) &&
                     (state != rx_ctrl_pkg::ST_RECEIVE);
  assign rssi_rise = rssi_threshold_flag && !rssi_prev;

  rx_timeout_timer u_rx_start_timer (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .start    (rx_entry),
    .stop     (rssi_threshold_flag || (!receiver_enable && !rx_entry)),
    .bit_tick (bit_tick),
    .field    (rx_start_timeout),
    .expired  (rx_timer_exp)
  );

  rx_timeout_timer u_rssi_timer (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .start    (rssi_rise && receiver_enable),
    .stop     (!receiver_enable && !rx_entry),
    .bit_tick (bit_tick),
    .field    (rssi_timeout),
    .expired  (rssi_timer_exp)
  );

  // Mode sequencer
  always_comb begin
    next_state     = state;
    next_osc_count = osc_count;
    if (sequencer_disable || target == rx_ctrl_pkg::ST_SLEEP ||
        target == rx_ctrl_pkg::ST_LISTEN) begin
      next_state = target;
    end else begin
      case (state)
        rx_ctrl_pkg::ST_SLEEP,
        rx_ctrl_pkg::ST_LISTEN: begin
          next_state     = rx_ctrl_pkg::ST_STANDBY;
          next_osc_count = 5'(rx_ctrl_pkg::OSC_START_CYCLES);
        end
        rx_ctrl_pkg::ST_STANDBY: begin
          if (osc_count != 5'h00) begin
            next_osc_count = osc_count - 5'h01;
          end else if (target != rx_ctrl_pkg::ST_STANDBY) begin
            next_state = rx_ctrl_pkg::ST_SYNTH;
          end
        end
        rx_ctrl_pkg::ST_SYNTH: begin
          if (target == rx_ctrl_pkg::ST_STANDBY) begin
            next_state = rx_ctrl_pkg::ST_STANDBY;
          end else if (target == rx_ctrl_pkg::ST_RECEIVE && pll_in_range) begin
            next_state = rx_ctrl_pkg::ST_RECEIVE;
          end
        end
        rx_ctrl_pkg::ST_RECEIVE: begin
          if (target != rx_ctrl_pkg::ST_RECEIVE) begin
            next_state = target;
          end
        end
        default: next_state = rx_ctrl_pkg::ST_SLEEP;
      endcase
    end
  end

  // Frequency correction
  assign offset_steps      = {8'h00, low_index_offset};
  // Sum kept at carrier width so a large offset cannot wrap the sign
  assign correction_amount = {{8{freq_error_measured[15]}}, freq_error_measured} +
                             (low_index_correction_enable ? {8'h00, offset_steps} :
                              24'h000000);
  always_comb begin
    next_afc_busy = afc_busy;
    next_afc_bits = afc_bits;
    next_carrier  = carrier_frequency;
    next_corr     = freq_correction_value;
    next_fei      = freq_error_value;
    next_cstart   = correction_start;
    if (carrier_frequency_load) begin
      next_carrier = carrier_frequency_init;
    end
    if (!afc_busy) begin
      if (auto_correction_enable && rx_entry) begin
        next_afc_busy = 1'b1;
        next_afc_bits = 3'(rx_ctrl_pkg::FEI_BITS);
        if (auto_clear_enable) begin
          next_carrier = 24'(carrier_frequency + {{8{freq_correction_value[15]}},
                                                  freq_correction_value});
          next_corr    = 16'h0000;
        end
      end else if (!auto_correction_enable && correction_start_write) begin
        next_afc_busy = 1'b1;
        next_cstart   = 1'b1;
        next_afc_bits = 3'(rx_ctrl_pkg::FEI_BITS);
      end
    end else if (bit_tick) begin
      next_afc_bits = afc_bits - 3'h1;
      if (afc_bits == 3'h1) begin
        next_afc_busy = 1'b0;
        next_cstart   = 1'b0;
        next_fei      = freq_error_measured;
        next_corr     = 16'(freq_correction_value + correction_amount[15:0]);
        next_carrier  = 24'(carrier_frequency - correction_amount);
      end
    end
  end

  // Temperature measurement
  always_comb begin
    next_temp_busy  = temp_busy;
    next_temp_count = temp_count;
    next_temp_value = temp_value;
    if (!temp_busy) begin
      if (temp_start_write && (state == rx_ctrl_pkg::ST_STANDBY ||
                               state == rx_ctrl_pkg::ST_SYNTH)) begin
        next_temp_busy  = 1'b1;
        next_temp_count = 12'(rx_ctrl_pkg::TEMP_CONV_CYCLES);
      end
    end else if (temp_count == 12'h000) begin
      next_temp_busy  = 1'b0;
      next_temp_value = ~temp_sensor_raw;
    end else begin
      next_temp_count = temp_count - 12'h001;
    end
  end

  assign next_timeout = rx_timer_exp || rssi_timer_exp;
  assign next_lock    = pll_in_range && (next_state == rx_ctrl_pkg::ST_SYNTH ||
                                         next_state == rx_ctrl_pkg::ST_RECEIVE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state                 <= rx_ctrl_pkg::ST_SLEEP;
      osc_count             <= 5'h00;
      rssi_prev             <= 1'b0;
      afc_busy              <= 1'b0;
      afc_bits              <= 3'h0;
      carrier_frequency     <= 24'h000000;
      freq_correction_value <= 16'h0000;
      freq_error_value      <= 16'h0000;
      correction_start      <= 1'b0;
      correction_bw_select  <= 1'b0;
      temp_busy             <= 1'b0;
      temp_running          <= 1'b0;
      temp_count            <= 12'h000;
      temp_value            <= 8'h00;
      timeout_irq           <= 1'b0;
      active_state          <= 5'h01;
      osc_enable            <= 1'b0;
      synth_enable          <= 1'b0;
      receiver_enable       <= 1'b0;
      pll_lock              <= 1'b0;
    end else begin
      state                 <= next_state;
      osc_count             <= next_osc_count;
      rssi_prev             <= rssi_threshold_flag;
      afc_busy              <= next_afc_busy;
      afc_bits              <= next_afc_bits;
      carrier_frequency     <= next_carrier;
      freq_correction_value <= next_corr;
      freq_error_value      <= next_fei;
      correction_start      <= next_cstart;
      correction_bw_select  <= next_afc_busy;
      temp_busy             <= next_temp_busy;
      temp_running          <= next_temp_busy;
      temp_count            <= next_temp_count;
      temp_value            <= next_temp_value;
      timeout_irq           <= next_timeout;
      active_state          <= next_state;
      osc_enable            <= next_state != rx_ctrl_pkg::ST_SLEEP;
      synth_enable          <= next_state == rx_ctrl_pkg::ST_SYNTH ||
                               next_state == rx_ctrl_pkg::ST_RECEIVE;
      receiver_enable       <= next_state == rx_ctrl_pkg::ST_RECEIVE;
      pll_lock              <= next_lock;
    end
  end
endmodule : rx_afc_timeout_mode_control
`default_nettype wire

// [include/rx_ctrl_pkg.sv]
// Constants for the receiver control block.
// Assumes one 25 MHz reference clock and bit-period enable pulses from a divider.
package rx_ctrl_pkg;
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned TEMP_MAX_US       = 100;
  // Longest time rounds down; conversion is set well inside it
  localparam int unsigned TEMP_MAX_CYCLES   = TEMP_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned TEMP_CONV_CYCLES  = TEMP_MAX_CYCLES / 2;
  localparam int unsigned FEI_BITS          = 4;
  localparam int unsigned TIMEOUT_BIT_MULT  = 8;
  localparam int unsigned LOW_INDEX_STEP_HZ = 488;
  localparam int unsigned OSC_START_CYCLES  = 16;
  localparam logic [7:0]  BIT_DIV_RESET     = 8'h63;
  localparam logic [2:0]  MODE_SLEEP        = 3'h0;
  localparam logic [2:0]  MODE_STANDBY      = 3'h1;
  localparam logic [2:0]  MODE_SYNTH        = 3'h2;
  localparam logic [2:0]  MODE_RECEIVE      = 3'h4;

  typedef enum logic [4:0] {
    ST_SLEEP   = 5'h01,
    ST_STANDBY = 5'h02,
    ST_SYNTH   = 5'h04,
    ST_RECEIVE = 5'h08,
    ST_LISTEN  = 5'h10
  } op_state_t;
endpackage : rx_ctrl_pkg

// [rtl/bit_rate_divider.sv]
// One-cycle enable per bit period from the reference clock.
// Assumes the divide value is held steady by the controller.
`timescale 1ns/1ps
`default_nettype none
module bit_rate_divider (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] divide,
  output var  logic       bit_tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_bit_tick;

  always_comb begin
    next_bit_tick = 1'b0;
    next_count    = count - 8'h01;
    if (count == 8'h00) begin
      next_count    = divide;
      next_bit_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count    <= 8'h00;
      bit_tick <= 1'b0;
    end else begin
      count    <= next_count;
      bit_tick <= next_bit_tick;
    end
  end
endmodule : bit_rate_divider
`default_nettype wire

// [rtl/rx_timeout_timer.sv]
// Bit-period down counter: loads field times eight, fires once at zero.
// Assumes bit_tick is a one-cycle enable; a zero field disables the timer.
`timescale 1ns/1ps
`default_nettype none
module rx_timeout_timer (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic       bit_tick,
  input  wire logic [7:0] field,
  output var  logic       expired
);
  logic [10:0] count;
  logic [10:0] next_count;
  logic        armed;
  logic        next_armed;
  logic        next_expired;

  always_comb begin
    next_count   = count;
    next_armed   = armed;
    next_expired = 1'b0;
    if (stop) begin
      next_armed = 1'b0;
    end else if (start) begin
      next_count = 11'(field * rx_ctrl_pkg::TIMEOUT_BIT_MULT);
      next_armed = (field != 8'h00);
    end else if (armed && bit_tick) begin
      next_count = count - 11'h001;
      if (count == 11'h001) begin
        next_armed   = 1'b0;
        next_expired = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count   <= 11'h000;
      armed   <= 1'b0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      armed   <= next_armed;
      expired <= next_expired;
    end
  end
endmodule : rx_timeout_timer
`default_nettype wire

// [tb/rx_ctrl_asserts.sv]
// Port checker for the receiver control block.
// Assumes bit_divide is kept small, so one correction ends within 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module rx_ctrl_asserts (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [2:0] mode_field,
  input wire logic       listen_enable,
  input wire logic       sequencer_disable,
  input wire logic       auto_correction_enable,
  input wire logic       correction_start_write,
  input wire logic       pll_in_range,
  input wire logic       temp_start_write,
  input wire logic       correction_start,
  input wire logic       temp_running,
  input wire logic       timeout_irq,
  input wire logic [4:0] active_state,
  input wire logic       synth_enable,
  input wire logic       receiver_enable,
  input wire logic       pll_lock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [11:0] run_cnt;
  logic [11:0] next_run_cnt;
  logic        temp_ok;
  assign temp_ok = (active_state == rx_ctrl_pkg::ST_STANDBY)
                 | (active_state == rx_ctrl_pkg::ST_SYNTH);
  // Length of the current temperature conversion
  always_comb begin
    next_run_cnt = temp_running ? run_cnt + 12'h001 : 12'h000;
  end
  always_ff @(posedge ref_clk) begin
    run_cnt <= reset_n ? next_run_cnt : 12'h000;
  end
  sequence s_rx_request;
    active_state == rx_ctrl_pkg::ST_SLEEP && mode_field == rx_ctrl_pkg::MODE_RECEIVE
      && !sequencer_disable && !listen_enable;
  endsequence
  sequence s_direct_synth;
    sequencer_disable && !listen_enable && mode_field == rx_ctrl_pkg::MODE_SYNTH;
  endsequence
  a_seq_standby: assert property (s_rx_request |=> active_state == rx_ctrl_pkg::ST_STANDBY)
    else $error("sleep to receive did not pass through standby");
  a_mode_direct: assert property (s_direct_synth [*2] |->
    active_state == rx_ctrl_pkg::ST_SYNTH && synth_enable && !receiver_enable)
    else $error("direct synth mode not applied");
  a_listen_force: assert property (listen_enable [*2] |-> active_state == rx_ctrl_pkg::ST_LISTEN)
    else $error("listen enable did not force listen");
  a_rx_after_lock: assert property (active_state == rx_ctrl_pkg::ST_RECEIVE
    && $past(active_state) == rx_ctrl_pkg::ST_SYNTH && !$past(sequencer_disable)
    |-> $past(pll_in_range)) else $error("receive entered before lock");
  a_lock_pin: assert property (pll_in_range [*2] |-> pll_lock)
    else $error("lock pin low while in range");
  a_temp_accept: assert property (temp_start_write && !temp_running && temp_ok |=> temp_running)
    else $error("temperature start not taken");
  a_temp_refuse: assert property (temp_start_write && !temp_running && !temp_ok |=> !temp_running)
    else $error("temperature start taken in wrong mode");
  a_temp_bound: assert property (run_cnt < 12'h9c4)
    else $error("temperature conversion too long");
  a_irq_pulse: assert property (timeout_irq |=> !timeout_irq)
    else $error("timeout pulse longer than one cycle");
  a_start_clear: assert property ($rose(correction_start) |-> ##[1:200] !correction_start)
    else $error("correction start bit did not clear");
  a_start_refuse: assert property (correction_start_write && auto_correction_enable
    && !correction_start && $stable(active_state) |=> !correction_start)
    else $error("start write taken with auto enable");
endmodule : rx_ctrl_asserts
bind rx_afc_timeout_mode_control rx_ctrl_asserts u_rx_ctrl_asserts (.*);
`default_nettype wire

// [tb/analog_front_model.sv]
// Behavioural analog side: PLL lock after settling, frequency error, sensor.
// Assumes the bench sets the error and raw sensor values.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model #(
  parameter int LOCK_CYCLES = 20
) (
  input  wire logic        ref_clk,
  input  wire logic        synth_enable,
  input  wire logic [15:0] err_set,
  input  wire logic [7:0]  raw_set,
  output var  logic        pll_in_range,
  output var  logic [15:0] freq_error_measured,
  output var  logic [7:0]  temp_sensor_raw
);
  int settle = 0;
  always @(posedge ref_clk) begin
    settle <= synth_enable ? settle + 1 : 0;
  end
  // Range is lost at once when the synthesizer stops
  assign pll_in_range = synth_enable && settle >= LOCK_CYCLES;
  // Error reading is meaningless without the synthesizer
  assign freq_error_measured = synth_enable ? err_set : ~err_set;
  assign temp_sensor_raw = raw_set;
endmodule : analog_front_model
`default_nettype wire

// [tb/rx_afc_timeout_mode_control_tb.sv]
// Self-checking bench for the receiver control block.
// Assumes the analog model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module rx_afc_timeout_mode_control_tb;
  logic        ref_clk = 1'b0, reset_n = 1'b0, listen_enable = 1'b0;
  logic        sequencer_disable = 1'b1, auto_correction_enable = 1'b0;
  logic        auto_clear_enable = 1'b0, correction_start_write = 1'b0;
  logic        low_index_correction_enable = 1'b0, temp_start_write = 1'b0;
  logic        rssi_threshold_flag = 1'b0, carrier_frequency_load = 1'b0;
  logic [2:0]  mode_field = 3'h0;
  logic [7:0]  bit_divide = 8'h03, low_index_offset = 8'h00, raw_set = 8'h00;
  logic [7:0]  rx_start_timeout = 8'h02, rssi_timeout = 8'h03, exp_raw;
  logic [15:0] err_set = 16'h0000, freq_error_measured, freq_error_value;
  logic [15:0] freq_correction_value, exp_corr = 16'h0000;
  logic [23:0] carrier_frequency_init = 24'h000000, carrier_frequency;
  logic [7:0]  temp_sensor_raw, temp_value;
  logic [4:0]  active_state;
  logic        pll_in_range, correction_start, correction_bw_select, temp_running;
  logic        timeout_irq, osc_enable, synth_enable, receiver_enable, pll_lock;
  logic [2:0]  modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  logic [2:0]  tmodes [4] = '{3'h1, 3'h2, 3'h0, 3'h4};
  int          error_cnt = 0, n_checks = 0, n, t;

  rx_afc_timeout_mode_control u_rx_afc_timeout_mode_control (.*);
  analog_front_model u_analog_front_model (.*);

  always #20 ref_clk = ~ref_clk;

  function automatic logic [4:0] state_of(input logic [2:0] m);
    case (m)
      rx_ctrl_pkg::MODE_STANDBY: state_of = 5'h02;
      rx_ctrl_pkg::MODE_SYNTH:   state_of = 5'h04;
      rx_ctrl_pkg::MODE_RECEIVE: state_of = 5'h08;
      default:                   state_of = 5'h01;
    endcase
  endfunction : state_of
  function automatic logic [23:0] corrected(input logic [23:0] f, input logic [15:0] e,
                                            input logic li, input logic [7:0] off);
    corrected = f - {{8{e[15]}}, e} - (li ? {16'h0000, off} : 24'h000000);
  endfunction : corrected
  function automatic int span(input logic [7:0] f);
    span = f * rx_ctrl_pkg::TIMEOUT_BIT_MULT * (bit_divide + 1);
  endfunction : span
  function automatic logic probe(input int w);
    case (w)
      0:       probe = active_state == 5'h08;
      1:       probe = timeout_irq;
      2:       probe = correction_start;
      3:       probe = temp_running;
      default: probe = correction_bw_select;
    endcase
  endfunction : probe

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : tick
  task automatic set_mode(input logic [2:0] m, input logic dis);
    @(posedge ref_clk);
    mode_field <= m;
    sequencer_disable <= dis;
  endtask : set_mode
  task automatic pulse_start(input logic temp);
    @(posedge ref_clk);
    temp_start_write <= temp;
    correction_start_write <= !temp;
    @(posedge ref_clk);
    temp_start_write <= 1'b0;
    correction_start_write <= 1'b0;
  endtask : pulse_start
  task automatic wait_for(input int w, input logic lvl, output int c);
    c = 0;
    #1;
    while (probe(w) !== lvl && c < 3000) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask : wait_for
  task automatic load_carrier(input logic [15:0] e, input logic [7:0] off, input logic li);
    @(posedge ref_clk);
    err_set <= e;
    low_index_offset <= off;
    low_index_correction_enable <= li;
    carrier_frequency_init <= 24'($urandom);
    carrier_frequency_load <= 1'b1;
    @(posedge ref_clk);
    carrier_frequency_load <= 1'b0;
  endtask : load_carrier
  task automatic results;
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    tick(20000);
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(32'h89f17a98));
    tick(12);
    reset_n <= 1'b1;
    #1;
    cmp(active_state, 5'h01);
    cmp(carrier_frequency, 24'h000000);
    foreach (modes[i]) begin
      set_mode(modes[i], 1'b1);
      tick(2);
      #1;
      cmp(active_state, state_of(modes[i]));
      cmp({osc_enable, synth_enable, receiver_enable}, {modes[i] inside {3'h1, 3'h2, 3'h4},
          modes[i] inside {3'h2, 3'h4}, modes[i] == 3'h4});
    end
    @(posedge ref_clk);
    listen_enable <= 1'b1;
    tick(2);
    #1;
    cmp(active_state, 5'h10);
    @(posedge ref_clk);
    listen_enable <= 1'b0;
    set_mode(3'h0, 1'b1);
    tick(3);
    set_mode(3'h4, 1'b0);
    tick(1);
    #1;
    cmp(active_state, 5'h02);
    wait_for(0, 1'b1, n);
    cmp(pll_lock, 1'b1);
    cmp(receiver_enable, 1'b1);
    t = span(rx_start_timeout);
    wait_for(1, 1'b1, n);
    cmp(n > t - 7 && n < t + 7, 1'b1);
    @(posedge ref_clk);
    rssi_threshold_flag <= 1'b1;
    t = span(rssi_timeout);
    wait_for(1, 1'b1, n);
    cmp(n > t - 7 && n < t + 7, 1'b1);
    @(posedge ref_clk);
    rssi_threshold_flag <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (k < 2)
        load_carrier(16'($urandom), 8'($urandom), k[0]);
      else
        load_carrier(16'h8000, 8'hff, 1'b1);
      pulse_start(1'b0);
      #1;
      cmp(correction_start, 1'b1);
      tick(1);
      #1;
      cmp(correction_bw_select, 1'b1);
      wait_for(2, 1'b0, n);
      tick(2);
      #1;
      cmp(carrier_frequency, corrected(carrier_frequency_init, err_set,
                                       low_index_correction_enable, low_index_offset));
      cmp(freq_error_value, err_set);
      cmp(correction_bw_select, 1'b0);
      exp_corr = 16'(exp_corr + err_set +
                     (low_index_correction_enable ? {8'h00, low_index_offset} : 16'h0000));
      cmp(freq_correction_value, exp_corr);
    end
    @(posedge ref_clk);
    auto_correction_enable <= 1'b1;
    pulse_start(1'b0);
    #1;
    cmp(correction_start, 1'b0);
    // Automatic correction, first continuing, then with auto-clear
    for (int k = 0; k < 2; k++) begin
      set_mode(3'h1, 1'b1);
      auto_clear_enable <= k[0];
      load_carrier(16'($urandom), 8'h00, 1'b0);
      set_mode(3'h4, 1'b1);
      wait_for(4, 1'b1, n);
      wait_for(4, 1'b0, n);
      tick(2);
      #1;
      cmp(carrier_frequency, corrected(carrier_frequency_init +
                                       (k[0] ? {{8{exp_corr[15]}}, exp_corr} : 24'h000000),
                                       err_set, 1'b0, 8'h00));
      exp_corr = k[0] ? err_set : 16'(exp_corr + err_set);
      cmp(freq_correction_value, exp_corr);
    end
    @(posedge ref_clk);
    auto_correction_enable <= 1'b0;
    foreach (tmodes[i]) begin
      set_mode(tmodes[i], 1'b1);
      tick(2);
      raw_set <= 8'($urandom);
      pulse_start(1'b1);
      #1;
      cmp(temp_running, tmodes[i] == 3'h1 || tmodes[i] == 3'h2);
      wait_for(3, 1'b0, n);
      exp_raw = ~raw_set;
      if (tmodes[i] == 3'h1 || tmodes[i] == 3'h2) begin
        cmp(n < 2500, 1'b1);
        cmp(temp_value, exp_raw);
      end
    end
    results();
  end
endmodule : rx_afc_timeout_mode_control_tb
`default_nettype wire
